// [core/phy_reset_strap_interrupt_ctrl.v]
/*
 Reset sequencing, strap capture, address match and interrupt control.
 Assumes hw_reset_n and strap pins arrive asynchronously; events and
 management strobes are synchronous to clk_i.
*/
// Behaviour
// - Active-low interrupt output asserts on enabled status change.
// - Each condition gated by its own mask bit.
// - Reading the status register deasserts the interrupt.
// - Interrupt is a level held until the status read.
// - Any wake-on-LAN event sets interrupt bit 7, which event bit 7 also sets.
// - Straps sampled and latched when reset releases.
// - Init takes 100 ms; no management access before then.
// - Reset pulses shorter than 10 ms are ignored in run; during init any low pulse restarts reset.
// - Bus address from three strap bits, high means one.
// - Broadcast enable makes address zero also match.
// - A configurable dedicated broadcast address also matches.
// - Delay strap selects no extra receive clock delay or added delay.
// - Regulator strap: 00 external, 01 2.5 V, 1x 1.8 V.
// - Mode strap selects one of eight data flows.
// - Straps map from receive pins and LED pins.
// - Status register clears on read.
`timescale 1ns/100ps
`default_nettype none
`include "phy_ctrl_map.vh"

module phy_reset_strap_interrupt_ctrl #(
  parameter N_EVT       = 8,
  parameter WOL_BIT     = 7,
  parameter RESET_MS    = `RESET_MIN_MS,
  parameter INIT_MS     = `INIT_DELAY_MS,
  parameter RESET_CYC   = (RESET_MS * `PS_PER_MS) / `CLK_PERIOD_PS,
  parameter INIT_CYC    = (INIT_MS * `PS_PER_MS) / `CLK_PERIOD_PS
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             rst_b_i,
  // Hardware reset pin.
  input  wire             hw_reset_n_i,
  // Strap pins.
  input  wire [3:0]       rxd_i,
  input  wire             rx_ctl_i,
  input  wire             rx_clk_i,
  input  wire             led_pin_0_i,
  input  wire             led_pin_1_i,
  input  wire             led_pin_2_i,
  // Strap pin release.
  output wire             strap_release_o,
  // Events and interrupt control.
  input  wire [N_EVT-1:0] event_i,
  input  wire             wol_event_i,
  input  wire [N_EVT-1:0] interrupt_enable_mask_i,
  input  wire             status_read_i,
  output wire [N_EVT-1:0] interrupt_event_status_o,
  output wire             mgmt_interrupt_n_o,
  // Management address matching.
  input  wire             broadcast_address_cfg_i,
  input  wire             dedicated_bcast_en_i,
  input  wire [2:0]       dedicated_bcast_addr_i,
  input  wire [2:0]       frame_addr_i,
  output wire             addr_match_o,
  // Configuration outputs.
  output wire [2:0]       strap_bus_address_o,
  output wire             strap_rx_clock_delay_o,
  output wire [1:0]       strap_io_regulator_sel_o,
  output wire [2:0]       chip_mode_o,
  output wire [7:0]       mode_onehot_o,
  output wire             regulator_enable_o,
  output wire             regulator_1v8_o,
  output wire             init_busy_o,
  output wire             mgmt_ready_o,
  output wire             core_reset_o
);

  localparam ST_RUN   = 3'b001;
  localparam ST_RESET = 3'b010;
  localparam ST_INIT  = 3'b100;

  reg  [1:0]              rst_sync_ff;
  reg  [`STRAP_WIDTH-1:0] strap_sync1_ff;
  reg  [`STRAP_WIDTH-1:0] strap_sync2_ff;
  reg  [`STRAP_WIDTH-1:0] strap_ff;
  reg  [2:0]              state_ff;
  reg  [2:0]              nxt_state;
  reg  [31:0]             low_cnt_ff;
  reg  [31:0]             init_cnt_ff;
  reg                     armed_ff;
  reg                     match_ff;
  reg                     st_busy;
  reg                     st_reset;
  reg                     st_ready;
  wire [1:0]              reg_flags;
  wire [`STRAP_WIDTH-1:0] strap_pins;
  wire                    pin_low;
  wire [N_EVT-1:0]        all_events;

  ////////////////////////////////////////////////////////////////////////////
  // Pin order into the strap vector.
  assign strap_pins = {led_pin_2_i, led_pin_1_i,
                       rx_ctl_i, rx_clk_i, led_pin_0_i,
                       rxd_i[0], rxd_i[3:1]};

  function [7:0] mode_decode;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_CU_RGMII: begin
          mode_decode = 8'h01;
        end
        `MODE_FIBER_RGMII: begin
          mode_decode = 8'h02;
        end
        `MODE_DUAL_AUTO: begin
          mode_decode = 8'h04;
        end
        `MODE_CU_SGMII: begin
          mode_decode = 8'h08;
        end
        `MODE_BRIDGE_S2R: begin
          mode_decode = 8'h10;
        end
        `MODE_BRIDGE_R2S: begin
          mode_decode = 8'h20;
        end
        `MODE_MC_AUTO: begin
          mode_decode = 8'h40;
        end
        `MODE_MC_FORCE: begin
          mode_decode = 8'h80;
        end
        default: begin
          mode_decode = 8'h00;
        end
      endcase
    end
  endfunction

  // Bit 1 enables the regulator, bit 0 picks 1.8 V over 2.5 V.
  function [1:0] reg_decode;
    input [1:0] sel;
    begin
      if (sel == `REG_EXTERNAL) begin
        reg_decode = 2'h0;
      end else if (sel == `REG_2V5) begin
        reg_decode = 2'h2;
      end else begin
        reg_decode = 2'h3;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; only the second stage is read.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      // Seen as a held pin, so capture waits for a real synced release.
      rst_sync_ff    <= 2'h0;
      strap_sync1_ff <= {`STRAP_WIDTH{1'b0}};
      strap_sync2_ff <= {`STRAP_WIDTH{1'b0}};
    end else begin
      rst_sync_ff    <= {rst_sync_ff[0], hw_reset_n_i};
      strap_sync1_ff <= strap_pins;
      strap_sync2_ff <= strap_sync1_ff;
    end
  end

  assign pin_low = ~rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer.  In run a short glitch only restarts the low-time count; in init any low pin returns to reset.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (pin_low && low_cnt_ff >= RESET_CYC - 1) begin
          nxt_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!pin_low) begin
          nxt_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (pin_low) begin
          nxt_state = ST_RESET;
        end else if (init_cnt_ff >= INIT_CYC - 1) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The low-time count saturates, so a very long pulse cannot wrap it.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      low_cnt_ff <= 32'h0;
    end else if (pin_low && low_cnt_ff < RESET_CYC) begin
      low_cnt_ff <= low_cnt_ff + 32'h1;
    end else if (!pin_low) begin
      low_cnt_ff <= 32'h0;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      init_cnt_ff <= 32'h0;
    end else if (state_ff == ST_INIT) begin
      init_cnt_ff <= init_cnt_ff + 32'h1;
    end else begin
      init_cnt_ff <= 32'h0;
    end
  end

  // Capture once on release; later pin activity is normal traffic.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      armed_ff <= 1'b1;
      strap_ff <= {`STRAP_WIDTH{1'b0}};
    end else if (state_ff == ST_RESET && !pin_low) begin
      strap_ff <= strap_sync2_ff;
      armed_ff <= 1'b0;
    end else if (state_ff == ST_RESET) begin
      armed_ff <= 1'b1;
    end
  end

  // An illegal state code reads as reset, the same as the next state.
  always @* begin
    st_busy  = 1'b0;
    st_reset = 1'b0;
    st_ready = 1'b0;
    case (state_ff)
      ST_RUN: begin
        st_ready = 1'b1;
      end
      ST_RESET: begin
        st_reset = 1'b1;
      end
      ST_INIT: begin
        st_busy = 1'b1;
      end
      default: begin
        st_reset = 1'b1;
      end
    endcase
  end

  assign init_busy_o     = st_busy;
  assign core_reset_o    = st_reset;
  assign mgmt_ready_o    = st_ready;
  assign strap_release_o = ~armed_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration from latched straps.
  assign strap_bus_address_o =
    strap_ff[`STRAP_ADDR_HI:`STRAP_ADDR_LO];
  assign strap_rx_clock_delay_o = strap_ff[`STRAP_DELAY_BIT];
  assign strap_io_regulator_sel_o =
    strap_ff[`STRAP_REG_HI:`STRAP_REG_LO];
  assign reg_flags          = reg_decode(strap_io_regulator_sel_o);
  assign regulator_enable_o = reg_flags[1];
  assign regulator_1v8_o    = reg_flags[0];
  assign chip_mode_o = strap_ff[`STRAP_MODE_HI:`STRAP_MODE_LO];
  assign mode_onehot_o = mode_decode(chip_mode_o);

  ////////////////////////////////////////////////////////////////////////////
  // Address match, registered so the answer is a clean flop.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= (frame_addr_i == strap_bus_address_o)
        || (broadcast_address_cfg_i
            && frame_addr_i == `BCAST_ADDR_ZERO)
        || (dedicated_bcast_en_i
            && frame_addr_i == dedicated_bcast_addr_i);
    end
  end

  assign addr_match_o = match_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-on-LAN folds into status bit WOL_BIT, which event_i[WOL_BIT] also sets.
  assign all_events = event_i | ({{(N_EVT-1){1'b0}}, wol_event_i}
                                 << WOL_BIT);

  irq_event_unit #(
    .N_EVT (N_EVT)
  ) u_irq (
    .clk_i                    (clk_i),
    .rst_b_i                  (rst_b_i),
    .event_i                  (all_events),
    .interrupt_enable_mask_i  (interrupt_enable_mask_i),
    .status_read_i            (status_read_i),
    .interrupt_event_status_o (interrupt_event_status_o),
    .mgmt_interrupt_n_o       (mgmt_interrupt_n_o)
  );

endmodule

`default_nettype wire

// [core/phy_ctrl_map.vh]
/*
 Constants for the reset, strap and interrupt control block.
 Assumes inclusion by bare name from design files under core/.
*/
`ifndef PHY_CTRL_MAP_VH
`define PHY_CTRL_MAP_VH

// Clock period in picoseconds (125 MHz).
`define CLK_PERIOD_PS       32'h00001F40
// Reset pulse must last this long to be honoured.
`define RESET_MIN_MS        32'h0000000A
// Initialisation time after reset release.
`define INIT_DELAY_MS       32'h00000064
// Picoseconds per millisecond, wide so the cycle products cannot overflow.
`define PS_PER_MS           64'h000000003B9ACA00

// Strap vector bit positions (sampled pin order).
`define STRAP_MODE_HI       2
`define STRAP_MODE_LO       0
`define STRAP_DELAY_BIT     3
`define STRAP_ADDR_HI       6
`define STRAP_ADDR_LO       4
`define STRAP_REG_LO        7
`define STRAP_REG_HI        8
`define STRAP_WIDTH         9

// Regulator selections.
`define REG_EXTERNAL        2'h0
`define REG_2V5             2'h1

// Chip mode codes.
`define MODE_CU_RGMII       3'h0
`define MODE_FIBER_RGMII    3'h1
`define MODE_DUAL_AUTO      3'h2
`define MODE_CU_SGMII       3'h3
`define MODE_BRIDGE_S2R     3'h4
`define MODE_BRIDGE_R2S     3'h5
`define MODE_MC_AUTO        3'h6
`define MODE_MC_FORCE       3'h7

// Broadcast management address and reset values.
`define BCAST_ADDR_ZERO     3'h0
`define EVT_RESET           8'h00
`define MODE_COUNT          8

`endif

// [core/irq_event_unit.v]
/*
 Interrupt event latch: sticky status bits, mask gating and clear on read.
 Assumes events and read strobe are synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "phy_ctrl_map.vh"

module irq_event_unit #(
  parameter N_EVT = 8
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             rst_b_i,
  // Events and control.
  input  wire [N_EVT-1:0] event_i,
  input  wire [N_EVT-1:0] interrupt_enable_mask_i,
  input  wire             status_read_i,
  // Status and interrupt.
  output wire [N_EVT-1:0] interrupt_event_status_o,
  output wire             mgmt_interrupt_n_o
);

  reg  [N_EVT-1:0] status_ff;
  reg  [N_EVT-1:0] nxt_status;
  reg              irq_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // A new event in the read cycle survives the clear, so none is lost.
  always @* begin
    nxt_status = status_ff;
    if (status_read_i) begin
      nxt_status = {N_EVT{1'b0}};
    end
    nxt_status = nxt_status | event_i;
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      status_ff <= `EVT_RESET;
      irq_n_ff  <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      // Low while any enabled bit stands; read clears it.
      irq_n_ff  <= ~|(nxt_status & interrupt_enable_mask_i);
    end
  end

  assign interrupt_event_status_o = status_ff;
  assign mgmt_interrupt_n_o       = irq_n_ff;

endmodule

`default_nettype wire

// [testbench/phy_ctrl_properties.sv]
/* Checker for the reset, strap and interrupt block.
   Assumes it is bound to the top module's ports, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] event_i,
  input wire logic       wol_event_i,
  input wire logic [7:0] interrupt_enable_mask_i,
  input wire logic       status_read_i,
  input wire logic [7:0] interrupt_event_status_o,
  input wire logic       mgmt_interrupt_n_o,
  input wire logic       broadcast_address_cfg_i,
  input wire logic [2:0] frame_addr_i,
  input wire logic       addr_match_o,
  input wire logic       strap_release_o,
  input wire logic [2:0] strap_bus_address_o,
  input wire logic [1:0] strap_io_regulator_sel_o,
  input wire logic [2:0] chip_mode_o,
  input wire logic [7:0] mode_onehot_o,
  input wire logic       regulator_enable_o,
  input wire logic       regulator_1v8_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_set;
    (event_i & interrupt_enable_mask_i) != 8'h00 |=> !mgmt_interrupt_n_o;
  endproperty
  a_set: assert property (p_set) else $error("irq not raised");
  property p_mask;
    !mgmt_interrupt_n_o |->
      (interrupt_event_status_o & $past(interrupt_enable_mask_i)) != 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_clear;
    status_read_i && event_i == 8'h00 && !wol_event_i |=>
      mgmt_interrupt_n_o && interrupt_event_status_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_hold;
    !mgmt_interrupt_n_o && !status_read_i && $stable(interrupt_enable_mask_i)
      |=> !mgmt_interrupt_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_wake;
    wol_event_i |=> interrupt_event_status_o[7];
  endproperty
  a_wake: assert property (p_wake) else $error("wake lost");
  property p_mode;
    mode_onehot_o == (8'h01 << chip_mode_o);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  property p_reg;
    regulator_enable_o == (strap_io_regulator_sel_o != 2'h0) &&
      regulator_1v8_o == strap_io_regulator_sel_o[1];
  endproperty
  a_reg: assert property (p_reg) else $error("regulator decode");
  property p_keep;
    strap_release_o && $past(strap_release_o) |->
      $stable({chip_mode_o, strap_bus_address_o, strap_io_regulator_sel_o});
  endproperty
  a_keep: assert property (p_keep) else $error("strap changed");
  property p_bcast;
    broadcast_address_cfg_i && frame_addr_i == 3'h0 |=> addr_match_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("no bcast match");
endmodule
`default_nettype wire

// [testbench/station_mgr_model.sv]
/* Station manager model: drives the hardware reset pin and status reads.
   Assumes the bench calls its tasks; it changes pins on falling edges. */
`timescale 1ns/100ps
`default_nettype none
module station_mgr_model (
  input  wire logic clk_i,
  input  wire logic mgmt_ready_i,
  output var  logic hw_reset_n_o,
  output var  logic status_read_o
);
  initial begin
    hw_reset_n_o = 1'b0;
    status_read_o = 1'b0;
  end
  task automatic hold_reset(input int n);
    @(negedge clk_i);
    hw_reset_n_o = 1'b0;
    repeat (n) @(negedge clk_i);
    hw_reset_n_o = 1'b1;
  endtask
  // A read before the device is ready is simply not issued.
  task automatic read_status;
    if (mgmt_ready_i === 1'b1) begin
      @(negedge clk_i);
      status_read_o = 1'b1;
      @(negedge clk_i);
      status_read_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
/* Self-checking bench for the reset, strap and interrupt block.
   Assumes short reset and init counts so the run stays brief. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int RC = 8;
  localparam int IC = 20;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       hw_reset_n_i, status_read_i, wol_event_i, rx_ctl_i, rx_clk_i;
  logic       led_pin_0_i, led_pin_1_i, led_pin_2_i, broadcast_address_cfg_i;
  logic       dedicated_bcast_en_i, strap_release_o, mgmt_interrupt_n_o;
  logic       addr_match_o, strap_rx_clock_delay_o, regulator_enable_o;
  logic       regulator_1v8_o, init_busy_o, mgmt_ready_o, core_reset_o;
  logic [3:0] rxd_i;
  logic [7:0] event_i, interrupt_enable_mask_i, interrupt_event_status_o;
  logic [7:0] mode_onehot_o;
  logic [2:0] dedicated_bcast_addr_i, frame_addr_i, strap_bus_address_o;
  logic [2:0] chip_mode_o;
  logic [1:0] strap_io_regulator_sel_o;
  int         num_errors = 0;
  int         checks = 0;
  phy_reset_strap_interrupt_ctrl #(
    .RESET_CYC(RC), .INIT_CYC(IC)
  ) u_phy_reset_strap_interrupt_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hw_reset_n_i(hw_reset_n_i),
    .rxd_i(rxd_i), .rx_ctl_i(rx_ctl_i), .rx_clk_i(rx_clk_i),
    .led_pin_0_i(led_pin_0_i), .led_pin_1_i(led_pin_1_i),
    .led_pin_2_i(led_pin_2_i), .strap_release_o(strap_release_o),
    .event_i(event_i), .wol_event_i(wol_event_i),
    .interrupt_enable_mask_i(interrupt_enable_mask_i),
    .status_read_i(status_read_i),
    .interrupt_event_status_o(interrupt_event_status_o),
    .mgmt_interrupt_n_o(mgmt_interrupt_n_o),
    .broadcast_address_cfg_i(broadcast_address_cfg_i),
    .dedicated_bcast_en_i(dedicated_bcast_en_i),
    .dedicated_bcast_addr_i(dedicated_bcast_addr_i),
    .frame_addr_i(frame_addr_i), .addr_match_o(addr_match_o),
    .strap_bus_address_o(strap_bus_address_o),
    .strap_rx_clock_delay_o(strap_rx_clock_delay_o),
    .strap_io_regulator_sel_o(strap_io_regulator_sel_o),
    .chip_mode_o(chip_mode_o), .mode_onehot_o(mode_onehot_o),
    .regulator_enable_o(regulator_enable_o),
    .regulator_1v8_o(regulator_1v8_o), .init_busy_o(init_busy_o),
    .mgmt_ready_o(mgmt_ready_o), .core_reset_o(core_reset_o));
  station_mgr_model u_station_mgr_model (.clk_i(clk_i),
    .mgmt_ready_i(mgmt_ready_o),
    .hw_reset_n_o(hw_reset_n_i), .status_read_o(status_read_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_straps(input logic [2:0] i);
    int n;
    logic [2:0] a;
    n = 0;
    a = ~i;
    rxd_i = {i, i[0]};
    {rx_ctl_i, rx_clk_i, led_pin_0_i} = a;
    {led_pin_2_i, led_pin_1_i} = i[1:0];
    u_station_mgr_model.hold_reset(RC + 2);
    check(core_reset_o, 1);
    while (mgmt_ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
      if (n == 4) begin
        check(init_busy_o, 1);
      end
    end
    check(n > IC, 1);
    check(chip_mode_o, i);
    check(mode_onehot_o, 8'h01 << i);
    check(strap_rx_clock_delay_o, i[0]);
    check(strap_bus_address_o, a);
    check(strap_io_regulator_sel_o, i[1:0]);
    check(regulator_1v8_o, i[1]);
    check(regulator_enable_o, i[1:0] != 2'h0);
    check(strap_release_o, 1);
    rxd_i = ~rxd_i;
    led_pin_0_i = ~led_pin_0_i;
    repeat (3) @(negedge clk_i);
    check(chip_mode_o, i);
    check(strap_bus_address_o, a);
  endtask
  task automatic t_short;
    u_station_mgr_model.hold_reset(RC - 3);
    repeat (6) @(negedge clk_i);
    check(core_reset_o, 0);
    check(mgmt_ready_o, 1);
  endtask
  task automatic t_irq;
    interrupt_enable_mask_i = 8'h01;
    event_i = 8'h02;
    @(negedge clk_i);
    check(mgmt_interrupt_n_o, 1);
    event_i = 8'h01;
    @(negedge clk_i);
    event_i = 8'h00;
    check(interrupt_event_status_o, 8'h03);
    check(mgmt_interrupt_n_o, 0);
    repeat (4) @(negedge clk_i);
    check(mgmt_interrupt_n_o, 0);
    u_station_mgr_model.read_status();
    @(negedge clk_i);
    check(mgmt_interrupt_n_o, 1);
    check(interrupt_event_status_o, 8'h00);
    interrupt_enable_mask_i = 8'h80;
    wol_event_i = 1'b1;
    @(negedge clk_i);
    wol_event_i = 1'b0;
    @(negedge clk_i);
    check(interrupt_event_status_o, 8'h80);
    check(mgmt_interrupt_n_o, 0);
    u_station_mgr_model.read_status();
  endtask
  task automatic try_addr(input logic b, input logic d, input logic [2:0] f,
                          input logic exp);
    broadcast_address_cfg_i = b;
    dedicated_bcast_en_i = d;
    frame_addr_i = f;
    @(negedge clk_i);
    check(addr_match_o, exp);
  endtask
  initial begin
    {rxd_i, rx_ctl_i, rx_clk_i} = 6'h00;
    {led_pin_0_i, led_pin_1_i, led_pin_2_i} = 3'h0;
    {event_i, interrupt_enable_mask_i, wol_event_i} = 17'h00000;
    {broadcast_address_cfg_i, dedicated_bcast_en_i} = 2'h0;
    dedicated_bcast_addr_i = 3'h3;
    frame_addr_i = 3'h1;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int k = 7; k >= 0; k--) t_straps(k[2:0]);
    t_short();
    t_irq();
    try_addr(1'b1, 1'b0, 3'h0, 1'b1);
    try_addr(1'b0, 1'b0, 3'h0, 1'b0);
    try_addr(1'b0, 1'b1, 3'h3, 1'b1);
    try_addr(1'b0, 1'b0, 3'h3, 1'b0);
    try_addr(1'b0, 1'b0, 3'h7, 1'b1);
    summarize();
  end
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule
bind phy_reset_strap_interrupt_ctrl phy_ctrl_checker u_phy_ctrl_checker (
  .clk_i, .rst_b_i, .event_i, .wol_event_i, .interrupt_enable_mask_i,
  .status_read_i, .interrupt_event_status_o, .mgmt_interrupt_n_o,
  .broadcast_address_cfg_i, .frame_addr_i, .addr_match_o, .strap_release_o,
  .strap_bus_address_o, .strap_io_regulator_sel_o, .chip_mode_o,
  .mode_onehot_o, .regulator_enable_o, .regulator_1v8_o);
`default_nettype wire
